/* bench/tb_urd_ctrl.sv */
// Self-checking bench for the receive channel control block.
// Assumes the far-side model and the bound checker beside the design.
`timescale 1ns/10ps
`include "urd_regs.svh"
module tb_urd_ctrl
   import urd_pkg::*;
;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_ack_o;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, tick = 1'b0, sof_i;
   logic [7:0] wb_adr_i = 8'h00, seed = 8'h00, rd;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [3:0] wb_sel_i = 4'hf;
   logic [1:0] rx_valid_i, rx_ready_o, rx_err_i, done_irq_o;
   logic [1:0] push = 2'h0, err = 2'h0, mode = 2'h0;
   logic [1:0][7:0] rx_data_i;
   logic buf_valid_o, buf_ready_i, desc_valid_o;
   urd_byte_t buf_data_o;
   urd_desc_t desc_o, last_desc;
   int failures = 0, checked = 0, descs = 0, taken = 0;
   int irqs[2] = '{0, 0};
   urd_byte_t q[$];

   urd_ctrl dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
      .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_valid_i, .rx_data_i,
      .rx_ready_o, .rx_err_i, .sof_i, .buf_valid_o, .buf_data_o,
      .buf_ready_i, .desc_valid_o, .desc_o, .done_irq_o);
   urd_far_model u_far (.clk_i, .rst_i, .push_i(push), .seed_i(seed),
      .err_i(err), .tick_i(tick), .mode_i(mode), .rx_ready_i(rx_ready_o),
      .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_err_o(rx_err_i),
      .sof_o(sof_i), .buf_ready_o(buf_ready_i));

   always #2 clk_i = ~clk_i;

   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic complete_run();
      if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Request stands until ack is sampled high at a rising edge
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n = 0;
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= {24'h0, d};
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && n++ < 50);
      if (n >= 50) failures++;
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rc(input logic [7:0] a, e, input string n);
      wb(a, 1'b0, 8'h00);
      chk(n, {24'h0, e}, {24'h0, rd});
   endtask

   task automatic ticks(input int k);
      repeat (k) begin
         tick <= 1'b1;
         @(posedge clk_i);
         tick <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
   endtask

   task automatic pulse(input int c, input logic e);
      if (e) err[c] <= 1'b1;
      else push[c] <= 1'b1;
      @(posedge clk_i);
      err <= 2'h0;
      push <= 2'h0;
      repeat (4) @(posedge clk_i);
   endtask

   always @(posedge clk_i) if (!rst_i) begin
      for (int c = 0; c < 2; c++) begin
         if (done_irq_o[c] === 1'b1) irqs[c]++;
         if (rx_valid_i[c] && rx_ready_o[c] === 1'b1) begin
            q.push_back({c[0], rx_data_i[c]});
            taken++;
         end
      end
      if (desc_valid_o === 1'b1) begin
         descs++;
         last_desc = desc_o;
      end
      if (buf_valid_o === 1'b1 && buf_ready_i) chk("fifo_out", q.pop_front(), buf_data_o);
   end

   // Tests need some 2000 cycles at most; this limit of 50000 cycles leaves wide margin
   initial begin
      #200000;
      failures++;
      complete_run();
   end

   initial begin
      logic [4:0] p;
      logic [7:0] b, s;
      int i0, d0, n;
      void'($urandom(52));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 0; a < 20; a += 4) rc(8'(a), 8'h00, "reset_val");
      wb(8'h10, 1'b1, 8'hff);
      rc(8'h10, 8'h00, "unmapped");
      wb(8'h00, 1'b1, 8'h3f);
      rc(8'h00, 8'h3f, "def_rw");
      wb_sel_i <= 4'he;
      wb(8'h00, 1'b1, 8'h55);
      wb_sel_i <= 4'hf;
      rc(8'h00, 8'h3f, "sel_off");
      wb(8'h04, 1'b1, 8'hff);
      rc(8'h04, 8'hfc, "csr_rw");
      wb(8'h04, 1'b1, 8'h00);
      wb(8'h00, 1'b1, 8'h00);
      for (int c = 0; c < 2; c++) begin
         b = 8'(8 * c);
         p = 5'($urandom_range(31, 1));
         s = {1'b1, p, 2'b00};
         seed <= 8'($urandom);
         wb(b + 8'h04, 1'b1, s);
         wb(b, 1'b1, 8'hc0);
         ticks(p + 1);
         rc(b + 8'h04, s, "no_first");
         pulse(c, 1'b0);
         ticks(p - 1);
         rc(b + 8'h04, s, "tmo_early");
         pulse(c, 1'b0);
         ticks(p - 1);
         rc(b + 8'h04, s, "tmo_reload");
         i0 = irqs[c];
         ticks(1);
         rc(b + 8'h04, s | 8'h02, "tmo_flag");
         rc(b, 8'h40, "tmo_run");
         chk("tmo_irq", i0 + 1, irqs[c]);
         chk("tmo_desc", {c[0], 8'h02, 1'b0}, last_desc);
         wb(b + 8'h04, 1'b1, s);
         rc(b + 8'h04, s | 8'h02, "w0_keeps");
         wb(b + 8'h04, 1'b1, s | 8'h02);
         rc(b + 8'h04, s, "w1_clears");
         wb(b, 1'b1, 8'h80);
         pulse(c, 1'b0);
         ticks(p);
         rc(b + 8'h04, s | 8'h02, "flag_noirq");
         rc(b, 8'h80, "run_stays");
         chk("irq_none", i0 + 1, irqs[c]);
         wb(b + 8'h04, 1'b1, {1'b0, p, 2'b10});
         pulse(c, 1'b0);
         ticks(p + 1);
         rc(b + 8'h04, {1'b0, p, 2'b00}, "count_off");
         pulse(c, 1'b1);
         rc(b, 8'h80, "err_kept");
         wb(b, 1'b1, 8'hc0);
         d0 = descs;
         pulse(c, 1'b1);
         rc(b, 8'h40, "err_halt");
         rc(b + 8'h04, {1'b0, p, 2'b00}, "err_flag");
         chk("err_irq", i0 + 1, irqs[c]);
         chk("err_desc", d0 + 1, descs);
      end
      mode <= 2'h2;
      taken = 0;
      wb(8'h00, 1'b1, 8'hc0);
      repeat (20) pulse(0, 1'b0);
      // FIFO plus the output register
      chk("fifo_fill", `URD_FIFO_DEPTH + 1, taken);
      mode <= 2'h1;
      for (n = 0; n < 500 && (q.size() != 0 || taken < 20); n++) @(posedge clk_i);
      chk("fifo_drain", 20, taken);
      @(posedge clk_i);
      chk("fifo_empty", 0, buf_valid_o);
      i0 = irqs[0];
      wb(8'h00, 1'b1, 8'h40);
      repeat (3) @(posedge clk_i);
      chk("sw_irq", i0 + 1, irqs[0]);
      complete_run();
   end
endmodule // tb_urd_ctrl

/* bench/urd_ctrl_props.sv */
// Concurrent checks on the ports of the receive channel control block.
// Assumes one clock domain and a synchronous, active-high reset.
`timescale 1ns/10ps
`include "urd_regs.svh"
module urd_ctrl_chk
   import urd_pkg::*;
#(
   parameter int NCH   = `URD_NCH,
   parameter int DEPTH = `URD_FIFO_DEPTH
) (
   input wire logic                  clk_i,        // System clock
   input wire logic                  rst_i,        // Sync reset
   input wire logic [`URD_ADR_W-1:0] wb_adr_i,     // Byte address
   input wire logic [31:0]           wb_dat_i,     // Write data
   input wire logic [31:0]           wb_dat_o,     // Read data
   input wire logic                  wb_we_i,      // Write
   input wire logic [3:0]            wb_sel_i,     // Byte lanes
   input wire logic                  wb_cyc_i,     // Cycle
   input wire logic                  wb_stb_i,     // Strobe
   input wire logic                  wb_ack_o,     // Acknowledge
   input wire logic [NCH-1:0]        rx_valid_i,   // Byte offered
   input wire logic [NCH-1:0][7:0]   rx_data_i,    // Byte
   input wire logic [NCH-1:0]        rx_ready_o,   // Byte taken
   input wire logic [NCH-1:0]        rx_err_i,     // Rcv error
   input wire logic                  sof_i,        // Frame seen
   input wire logic                  buf_valid_o,  // Byte ready
   input wire urd_byte_t             buf_data_o,   // Byte, chan
   input wire logic                  buf_ready_i,  // Taken
   input wire logic                  desc_valid_o, // Write-back
   input wire urd_desc_t             desc_o,       // Count, hold
   input wire logic [NCH-1:0]        done_irq_o    // Halt pulse
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked next cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits set");
   desc_hold_a: assert property (desc_valid_o |-> desc_o.hold == 1'b0)
      else $error("descriptor hold flag not cleared");
   irq_pulse_a: assert property (done_irq_o[0] |=> !done_irq_o[0])
      else $error("interrupt longer than one cycle");
   err_quiet_a: assert property (rx_err_i[0] |=> (!done_irq_o[0]) [*2])
      else $error("interrupt after receiver error");
   rdy_gap_a: assert property (rx_valid_i[0] && rx_ready_o[0] |=> rx_ready_o == 2'b00)
      else $error("ready offered right after a push");

   cover property (done_irq_o[0]);
   cover property (desc_valid_o && !done_irq_o[0]);
   cover property (buf_valid_o && !buf_ready_i);
endmodule // urd_ctrl_chk

bind urd_ctrl urd_ctrl_chk #(.NCH(NCH), .DEPTH(DEPTH)) u_chk (
   .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_valid_i, .rx_data_i, .rx_ready_o,
   .rx_err_i, .sof_i, .buf_valid_o, .buf_data_o, .buf_ready_i,
   .desc_valid_o, .desc_o, .done_irq_o);

/* bench/urd_far_model.sv */
// Model of the two receivers, the frame detector and the buffer manager.
// Assumes the bench requests bytes, errors and ticks one cycle at a time.
`timescale 1ns/10ps
module urd_far_model (
   input  wire logic       clk_i,      // System clock
   input  wire logic       rst_i,      // Sync reset
   input  wire logic [1:0] push_i,     // Queue one byte
   input  wire logic [7:0] seed_i,     // Data base value
   input  wire logic [1:0] err_i,      // Raise receiver error
   input  wire logic       tick_i,     // Raise frame tick
   input  wire logic [1:0] mode_i,     // 0 ready, 1 random, 2 stall
   input  wire logic [1:0] rx_ready_i, // Byte taken
   output logic [1:0]      rx_valid_o, // Byte offered
   output logic [1:0][7:0] rx_data_o,  // Byte
   output logic [1:0]      rx_err_o,   // Error pulse
   output logic            sof_o,      // Frame tick
   output logic            buf_ready_o // Buffer side accepts
);
   logic [1:0][5:0] pend_q;
   logic [1:0][7:0] nxt_q;
   logic [7:0]      lfsr_q;
   logic [1:0]      take;

   assign take = rx_valid_o & rx_ready_i;
   always_ff @(posedge clk_i) begin
      sof_o <= tick_i & !rst_i;
      rx_err_o <= err_i & {2{!rst_i}};
      lfsr_q <= rst_i ? 8'h5a : {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5]};
      for (int c = 0; c < 2; c++) begin
         pend_q[c] <= rst_i ? 6'h00 : pend_q[c] + 6'(push_i[c]) - 6'(take[c]);
         nxt_q[c] <= rst_i ? 8'h00 : nxt_q[c] + 8'(take[c]);
      end
   end
   // An idle data line shows the inverse of the last byte, never a hold
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         rx_valid_o[c] = pend_q[c] != 6'h00;
         rx_data_o[c] = rx_valid_o[c] ? seed_i + nxt_q[c]
                                      : ~(seed_i + nxt_q[c] - 8'h01);
      end
      buf_ready_o = (mode_i == 2'h0) | (mode_i == 2'h1 & lfsr_q[0]);
   end
endmodule // urd_far_model

/* rtl/urd_ctrl.sv */
// Control and status for two UART receive channels feeding the
// USB input buffers: Wishbone register slave, run bits, time-out
// and halt handling, and the byte FIFO toward the buffer manager.
// Assumes receivers, frame detector and buffer manager run on
// clk_i; none of their signals needs synchronising.
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`include "urd_regs.svh"
module urd_ctrl
   import urd_pkg::*;
#(
   parameter int NCH   = `URD_NCH,
   parameter int DEPTH = `URD_FIFO_DEPTH
) (
   input  wire logic                 clk_i,        // System clock
   input  wire logic                 rst_i,        // Sync reset
   // Wishbone classic slave
   input  wire logic [`URD_ADR_W-1:0] wb_adr_i,    // Byte address
   input  wire logic [31:0]          wb_dat_i,     // Write data
   output logic      [31:0]          wb_dat_o,     // Read data
   input  wire logic                 wb_we_i,      // Write
   input  wire logic [3:0]           wb_sel_i,     // Byte lanes
   input  wire logic                 wb_cyc_i,     // Cycle
   input  wire logic                 wb_stb_i,     // Strobe
   output logic                      wb_ack_o,     // Acknowledge
   // UART receivers and frame detector
   input  wire logic [NCH-1:0]       rx_valid_i,   // Byte offered
   input  wire logic [NCH-1:0][7:0]  rx_data_i,    // Byte
   output logic      [NCH-1:0]       rx_ready_o,   // Byte taken
   input  wire logic [NCH-1:0]       rx_err_i,     // Rcv error
   input  wire logic                 sof_i,        // Frame seen
   // USB buffer manager
   output logic                      buf_valid_o,  // Byte ready
   output urd_byte_t                 buf_data_o,   // Byte, chan
   input  wire logic                 buf_ready_i,  // Taken
   output logic                      desc_valid_o, // Write-back
   output urd_desc_t                 desc_o,       // Count, hold
   // To the microcontroller
   output logic      [NCH-1:0]       done_irq_o    // Halt pulse
);

   // Register select: {valid, channel, csr}
   function automatic logic [2:0] reg_sel(
      input logic [`URD_ADR_W-1:0] adr
   );
      logic ok;
      ok = ((adr & `URD_MAP_MASK) == `URD_DEF0_OFS);
      return {ok, adr[`URD_CH_BIT], adr[`URD_CSR_BIT]};
   endfunction

   // Register and channel state
   logic [NCH-1:0][7:0]            def_q, def_d;
   logic [NCH-1:0][7:0]            csr_q, csr_d;
   logic [NCH-1:0]                 first_q, first_d;
   logic [NCH-1:0][`URD_BCNT_W-1:0] bcnt_q, bcnt_d;
   urd_cause_t                     cause_q [NCH];
   urd_cause_t                     cause_d [NCH];
   logic [NCH-1:0]                 irq_q, irq_d;
   logic                           dvld_q, dvld_d;
   urd_desc_t                      desc_q, desc_d;
   logic [NCH-1:0]                 pend_q, pend_d;
   logic [NCH-1:0][`URD_BCNT_W-1:0] pcnt_q, pcnt_d;

   // Bus state
   logic                           ack_q, ack_d;
   logic [31:0]                    rdat_q, rdat_d;

   // Input path state
   logic [NCH-1:0]                 rdy_q, rdy_d;
   logic                           tok_q, tok_d;
   logic                           sof_q;

   // Internal nets
   logic [NCH-1:0]                 acc;
   logic [NCH-1:0]                 expire;
   logic [NCH-1:0]                 run;
   logic                           tick;
   logic                           push;
   logic                           fifo_rdy;
   urd_byte_t                      push_data;
   logic [2:0]                     sel;
   logic                           wr;
   logic                           rd;
   logic [NCH-1:0]                 halt;
   logic                           ovld_q, ovld_d;
   urd_byte_t                      odat_q, odat_d;
   logic                           f_valid;
   logic                           f_take;
   urd_byte_t                      f_data;

   assign sel  = reg_sel(wb_adr_i);
   assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & wb_sel_i[0];
   assign rd   = wb_cyc_i & wb_stb_i & ~ack_q;
   assign tick = sof_i & ~sof_q;
   assign acc  = rx_valid_i & rdy_q;
   assign push = |acc;

   // Only one channel is offered per cycle, so acc is one-hot
   always_comb begin
      push_data = '0;
      for (int c = 0; c < NCH; c++) begin
         if (acc[c]) begin
            push_data.ch   = c[0];
            push_data.data = rx_data_i[c];
         end
      end
   end

   // Input offer: one channel per cycle, alternating.
   // Ready is withheld the cycle after a push, so a registered
   // ready can never overrun the FIFO; this halves peak rate.
   always_comb begin
      tok_d = ~tok_q;
      for (int c = 0; c < NCH; c++) begin
         rdy_d[c] = fifo_rdy & ~push & def_d[c][`URD_EN_BIT]
                  & (tok_d == c[0]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdy_q <= '0;
         tok_q <= 1'b0;
         sof_q <= 1'b0;
      end else begin
         rdy_q <= rdy_d;
         tok_q <= tok_d;
         sof_q <= sof_i;
      end
   end

   // Channel control and registers
   always_comb begin
      logic en_old;
      logic en_new;
      logic csr_hit;
      logic chan_hit;
      en_old  = 1'b0;
      en_new  = 1'b0;
      csr_hit = 1'b0;
      chan_hit = 1'b0;
      def_d   = def_q;
      csr_d   = csr_q;
      first_d = first_q;
      bcnt_d  = bcnt_q;
      irq_d   = '0;
      halt    = '0;
      for (int c = 0; c < NCH; c++) begin
         cause_d[c] = cause_q[c];
         en_old     = def_q[c][`URD_EN_BIT];
         chan_hit   = wr & sel[2] & (sel[1] == c[0]);
         csr_hit    = chan_hit & sel[0];

         // Firmware writes
         if (chan_hit & ~sel[0]) begin
            def_d[c] = wb_dat_i[7:0];
            if (en_old & ~wb_dat_i[`URD_EN_BIT]) begin
               cause_d[c] = CAUSE_SW;
            end
         end
         if (csr_hit) begin
            csr_d[c][`URD_TEN_BIT] = wb_dat_i[`URD_TEN_BIT];
            csr_d[c][`URD_PER_HI:`URD_PER_LO] =
               wb_dat_i[`URD_PER_HI:`URD_PER_LO];
            if (wb_dat_i[`URD_TMO_BIT]) begin
               csr_d[c][`URD_TMO_BIT] = 1'b0;
            end
         end
         csr_d[c][`URD_RSV_BIT] = 1'b0;

         // Byte count restarts with each new run
         if (~en_old & def_d[c][`URD_EN_BIT]) begin
            bcnt_d[c]  = '0;
            first_d[c] = 1'b0;
            cause_d[c] = CAUSE_NONE;
         end
         if (acc[c]) begin
            bcnt_d[c]  = bcnt_q[c] + 1'b1;
            first_d[c] = 1'b1;
         end

         // Time-out: the flag wins over a same-cycle clear
         if (expire[c] & en_old) begin
            csr_d[c][`URD_TMO_BIT] = 1'b1;
            if (def_q[c][`URD_INE_BIT]) begin
               def_d[c][`URD_EN_BIT] = 1'b0;
               cause_d[c] = CAUSE_TMO;
            end
         end

         // Receiver error leaves the flag at zero
         if (rx_err_i[c] & en_old & def_q[c][`URD_INE_BIT]) begin
            def_d[c][`URD_EN_BIT] = 1'b0;
            cause_d[c] = CAUSE_ERR;
         end

         // Falling run bit: write back and maybe interrupt
         en_new = def_d[c][`URD_EN_BIT];
         if (en_old & ~en_new) begin
            irq_d[c] = def_q[c][`URD_INE_BIT]
                     & (cause_d[c] != CAUSE_ERR);
            halt[c]  = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         def_q   <= {NCH{`URD_DEF_RST}};
         csr_q   <= {NCH{`URD_CSR_RST}};
         first_q <= '0;
         bcnt_q  <= '0;
         irq_q   <= '0;
         for (int c = 0; c < NCH; c++) begin
            cause_q[c] <= CAUSE_NONE;
         end
      end else begin
         def_q   <= def_d;
         csr_q   <= csr_d;
         first_q <= first_d;
         bcnt_q  <= bcnt_d;
         irq_q   <= irq_d;
         for (int c = 0; c < NCH; c++) begin
            cause_q[c] <= cause_d[c];
         end
      end
   end

   // Write-back queue: both channels can halt on one tick, so
   // each keeps its request until the descriptor port sends it
   always_comb begin
      logic sent;
      sent   = 1'b0;
      pend_d = pend_q;
      pcnt_d = pcnt_q;
      dvld_d = 1'b0;
      desc_d = desc_q;
      for (int c = 0; c < NCH; c++) begin
         if (pend_q[c] & ~sent) begin
            sent         = 1'b1;
            pend_d[c]    = 1'b0;
            dvld_d       = 1'b1;
            desc_d.ch    = c[0];
            desc_d.count = pcnt_q[c];
            desc_d.hold  = 1'b0;
         end
         if (halt[c]) begin
            pend_d[c] = 1'b1;
            pcnt_d[c] = bcnt_d[c];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= '0;
         pcnt_q <= '0;
         dvld_q <= 1'b0;
         desc_q <= '0;
      end else begin
         pend_q <= pend_d;
         pcnt_q <= pcnt_d;
         dvld_q <= dvld_d;
         desc_q <= desc_d;
      end
   end

   // Wishbone slave: one wait state, unmapped reads give zero
   always_comb begin
      ack_d  = rd;
      rdat_d = '0;
      if (rd & sel[2]) begin
         rdat_d[7:0] = sel[0] ? csr_q[sel[1]] : def_q[sel[1]];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= '0;
      end else begin
         ack_q  <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   // Per-channel time-out counters
   for (genvar g = 0; g < NCH; g++) begin : g_tmo
      // Counting needs enable, run and a first byte
      assign run[g] = csr_q[g][`URD_TEN_BIT]
                    & def_q[g][`URD_EN_BIT] & first_q[g];
      urd_tmo u_tmo (
         .clk_i    (clk_i),
         .rst_i    (rst_i),
         .load_i   (acc[g]),
         .period_i (csr_q[g][`URD_PER_HI:`URD_PER_LO]),
         .run_i    (run[g]),
         .tick_i   (tick),
         .expire_o (expire[g])
      );
   end

   urd_fifo #(
      .W     ($bits(urd_byte_t)),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (push),
      .in_data_i   (push_data),
      .in_ready_o  (fifo_rdy),
      .out_valid_o (f_valid),
      .out_data_o  (f_data),
      .out_ready_i (f_take)
   );

   // Output register: the buffer side sees flops only; it holds
   // one byte beyond the FIFO, so the path stores DEPTH+1 bytes
   assign f_take = ~ovld_q | buf_ready_i;

   always_comb begin
      ovld_d = ovld_q;
      odat_d = odat_q;
      if (f_valid & f_take) begin
         ovld_d = 1'b1;
         odat_d = f_data;
      end else if (buf_ready_i) begin
         ovld_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovld_q <= 1'b0;
         odat_q <= '0;
      end else begin
         ovld_q <= ovld_d;
         odat_q <= odat_d;
      end
   end

   assign buf_valid_o  = ovld_q;
   assign buf_data_o   = odat_q;
   assign wb_dat_o     = rdat_q;
   assign wb_ack_o     = ack_q;
   assign rx_ready_o   = rdy_q;
   assign desc_valid_o = dvld_q;
   assign desc_o       = desc_q;
   assign done_irq_o   = irq_q;

endmodule // urd_ctrl

/* rtl/urd_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and one clock domain.
`timescale 1ns/10ps
module urd_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 16
) (
   input  wire logic         clk_i,       // System clock
   input  wire logic         rst_i,       // Sync reset, high
   input  wire logic         in_valid_i,  // Write request
   input  wire logic [W-1:0] in_data_i,   // Write data
   output logic              in_ready_o,  // Not full
   output logic              out_valid_o, // Not empty
   output logic [W-1:0]      out_data_o,  // Head word
   input  wire logic         out_ready_i  // Drain side accepts
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;

   assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_comb begin
      wr_d  = push ? wr_q + 1'b1 : wr_q;
      rd_d  = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q;
      if (push & ~pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop & ~push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end
endmodule // urd_fifo

/* rtl/urd_pkg.sv */
// Types shared by the receive channel control block.
// Assumes urd_regs.svh is on the include path.
`include "urd_regs.svh"
package urd_pkg;

   typedef enum logic [1:0] {
      CAUSE_NONE,
      CAUSE_TMO,
      CAUSE_ERR,
      CAUSE_SW
   } urd_cause_t;

   // One received byte tagged with its channel
   typedef struct packed {
      logic       ch;
      logic [7:0] data;
   } urd_byte_t;

   // Write-back to the input endpoint descriptor on halt
   typedef struct packed {
      logic                   ch;
      logic [`URD_BCNT_W-1:0] count;
      logic                   hold;
   } urd_desc_t;

endpackage

/* rtl/urd_regs.svh */
// Register map, field positions and reset values of the receive
// channel control block; included by the package, urd_ctrl and urd_tmo.
// Function
// - Interrupt enable low: no irq, no halt
// - Interrupt enable high: irq on run fall, except on receiver error
// - Firmware sets run bit; hardware clears it
// - Halt writes byte count, clears hold flag
// - Time-out halt interrupts, receiver error doesn't
// - Time-out flag set on expiry, write-1-clear
// - Period field reloads counter every byte
// - Counter decrements once per frame tick
// - Counter at zero: flag set; channel halted if interrupt enable high
// - Count only with enable, run, first byte
// - Count enable bit low: never times out
// - Flag zero on error, one on starvation
`ifndef URD_REGS_SVH
`define URD_REGS_SVH

`define URD_ADR_W        8
`define URD_CH_BIT       3
`define URD_CSR_BIT      2
`define URD_DEF0_OFS     8'h00
`define URD_CSR0_OFS     8'h04
`define URD_DEF1_OFS     8'h08
`define URD_CSR1_OFS     8'h0c
`define URD_MAP_MASK     8'hf3

`define URD_EN_BIT       7
`define URD_INE_BIT      6
`define URD_TEN_BIT      7
`define URD_PER_HI       6
`define URD_PER_LO       2
`define URD_TMO_BIT      1
`define URD_RSV_BIT      0

`define URD_DEF_RST      8'h00
`define URD_CSR_RST      8'h00
`define URD_PER_W        5
`define URD_BCNT_W       8
`define URD_FIFO_DEPTH   16
`define URD_NCH          2

`endif

/* rtl/urd_tmo.sv */
// Transaction time-out down-counter for one channel.
// Assumes tick_i is a one-cycle pulse per frame.
`timescale 1ns/10ps
`include "urd_regs.svh"
module urd_tmo
   import urd_pkg::*;
(
   input  wire logic                  clk_i,    // System clock
   input  wire logic                  rst_i,    // Sync reset, high
   input  wire logic                  load_i,   // Byte moved
   input  wire logic [`URD_PER_W-1:0] period_i, // Period in ms
   input  wire logic                  run_i,    // Counting allowed
   input  wire logic                  tick_i,   // Frame tick
   output logic                       expire_o  // Reached zero
);
   logic [`URD_PER_W-1:0] cnt_q, cnt_d;
   logic                  exp_q, exp_d;

   always_comb begin
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (load_i) begin
         cnt_d = period_i;
      end else if (run_i & tick_i & (cnt_q != '0)) begin
         cnt_d = cnt_q - 1'b1;
         exp_d = (cnt_q == `URD_PER_W'h01);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign expire_o = exp_q;
endmodule // urd_tmo
